// ==== core/ufm_params.svh ====
// Constants for the per-channel serial line control block: pin slots,
// frame timing, thresholds and activity-toggle timing.
// Assumes a 200 MHz core clock and a 16x oversampling tick per bit.
`ifndef UFM_PARAMS_SVH
`define UFM_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// GPIO slots with special functions
`define UFM_GPIO_W 10
`define UFM_PIN_CLK 0
`define UFM_PIN_REMOTE_RDY 2
`define UFM_PIN_LOCAL_RDY 3
`define UFM_PIN_CTS 4
`define UFM_PIN_RTS 5
`define UFM_PIN_HDX_B 5
`define UFM_PIN_HDX_A 7

////////////////////////////////////////////////////////////////////////////////
// Receive fill threshold used when the setting is zero
`define UFM_RX_THRESH_RST 10'h1c2

////////////////////////////////////////////////////////////////////////////////
// Bit timing in 16ths of a bit, and frame and data lengths in bits
`define UFM_SUB_MID 4'h7
`define UFM_SUB_LAST 4'hf
`define UFM_IR_BEG3 4'h7
`define UFM_IR_BEG4 4'h6
`define UFM_IR_END 4'h9
`define UFM_FRAME_BITS8 4'ha
`define UFM_FRAME_BITS9 4'hb
`define UFM_DATA_BITS8 4'h8
`define UFM_DATA_BITS9 4'h9

////////////////////////////////////////////////////////////////////////////////
// Transmit queue and activity toggle timing
`define UFM_TXQ_DEPTH 4
`define UFM_WORD_W 9
`define UFM_CLK_PERIOD_NS 5
`define UFM_ACT_PERIOD_NS 100000000
`define UFM_ACT_CYCLES (`UFM_ACT_PERIOD_NS / `UFM_CLK_PERIOD_NS)

`endif

// ==== core/ufm_pkg.sv ====
// Types shared by the line control block: flow modes, FSM states and
// status selectors. Assumes nothing of its surroundings.
package ufm_pkg;

  // Flow control modes; codes 3 and 4 are the two address matching modes
  typedef enum logic [2:0] {
    FLOW_NONE = 3'b000,
    FLOW_RTSCTS = 3'b001,
    FLOW_DTRDSR = 3'b010,
    FLOW_ADDR_FREE = 3'b011,
    FLOW_ADDR_GATED = 3'b100,
    FLOW_SOFT = 3'b101
  } ufm_flow_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_HOLD = 2'b10
  } ufm_tx_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_SHIFT = 1'b1
  } ufm_rx_t;

  // Selectable USB status shown on a status pin
  typedef enum logic [1:0] {
    STAT_SUSPEND = 2'b00,
    STAT_LOWPWR = 2'b01,
    STAT_BUSRST = 2'b10
  } ufm_stat_t;

endpackage : ufm_pkg

// ==== core/ufm_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module ufm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so both are exact
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  ////////////////////////////////////////////////////////////////////////////
  // Storage; no reset needed on the data words
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ufm_fifo

`default_nettype wire

// ==== core/ufm_line_ctrl.sv ====
// Per-channel serial line control: hardware and software flow control,
// address matching, half-duplex turn-around, IR coding, USB status pins,
// GPIO suspend behaviour and activity toggles.
// Assumes a 16x baud tick from the baud generator, a channel receive FIFO
// that always accepts and reports its fill, and USB state on this clock.
`timescale 1ns/1ps
`include "ufm_params.svh"
`default_nettype none

module ufm_line_ctrl
  import ufm_pkg::*;
#(
  parameter int ACT_CYCLES = `UFM_ACT_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic subTick,
  input wire ufm_flow_t flowMode,
  input wire logic halfDuplex,
  input wire logic nineBit,
  input wire logic [9:0] rxThreshold,
  input wire logic [7:0] startCharRegister,
  input wire logic [7:0] stopCharRegister,
  input wire logic rs485Enable,
  input wire logic rs485PinSel,
  input wire logic [3:0] turnaroundDelaySetting,
  input wire logic infraredSetting,
  input wire logic irPulseWide,
  input wire logic irRxInvert,
  input wire logic [8:0] txWord,
  input wire logic txValid,
  output logic txReady,
  output logic [8:0] rxWord,
  output logic rxValid,
  input wire logic [9:0] rxFifoLevel,
  output logic serialTx,
  input wire logic serialRx,
  input wire logic [`UFM_GPIO_W-1:0] gpioIn,
  input wire logic [`UFM_GPIO_W-1:0] gpioOut,
  input wire logic [`UFM_GPIO_W-1:0] gpioOe,
  output logic [`UFM_GPIO_W-1:0] gpioPinOut,
  output logic [`UFM_GPIO_W-1:0] gpioPinOe,
  input wire logic clkOutEnable,
  input wire logic clkOutLevel,
  input wire logic useSuspend,
  input wire logic [`UFM_GPIO_W-1:0] suspendLevel,
  input wire logic [`UFM_GPIO_W-1:0] suspendOpenDrain,
  input wire logic usbSuspended,
  input wire logic usbConfigured,
  input wire logic usbBusReset,
  input wire logic highPowerDevice,
  input wire ufm_stat_t stat1Select,
  input wire logic stat1Invert,
  input wire ufm_stat_t stat2Select,
  input wire logic stat2Invert,
  output logic usbStat1,
  output logic usbStat2,
  output logic txActivityPin,
  output logic rxActivityPin
);

  logic [`UFM_GPIO_W-1:0] gpioMeta;
  logic [`UFM_GPIO_W-1:0] gpioSync;
  logic rxMeta;
  logic rxSync;
  ufm_tx_t txState;
  ufm_rx_t rxState;
  logic [10:0] txShift;
  logic [3:0] txBits;
  logic [3:0] txSub;
  logic [3:0] holdCnt;
  logic [8:0] qData;
  logic qValid;
  logic qReady;
  logic pendValid;
  logic [7:0] pendChar;
  logic stopSent;
  logic softHalt;
  logic addrOpen;
  logic [3:0] irHold;
  logic [3:0] rxSub;
  logic [3:0] rxIdx;
  logic [8:0] rxShift;
  logic rxDone;
  logic [`UFM_GPIO_W-1:0] next_gpioPinOut;
  logic [`UFM_GPIO_W-1:0] next_gpioPinOe;
  logic [1:0] actPin;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gpioMeta <= '0;
      gpioSync <= '0;
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      gpioMeta <= gpioIn;
      gpioSync <= gpioMeta;
      rxMeta <= serialRx;
      rxSync <= rxMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and flow-control conditions
  logic softMode;
  logic addrMode;
  logic [9:0] rxLimit;
  logic rxFull;
  logic localReadyN;
  logic remoteBusy;
  logic [3:0] dataBits;
  logic suspendCtl;

  assign softMode = flowMode == FLOW_SOFT;
  assign addrMode = (flowMode == FLOW_ADDR_FREE) | (flowMode == FLOW_ADDR_GATED);
  // A zero threshold setting falls back to the power-on level
  assign rxLimit = (rxThreshold == 10'h000) ? `UFM_RX_THRESH_RST : rxThreshold;
  assign rxFull = rxFifoLevel >= rxLimit;
  assign localReadyN = rxFull;
  // Remote ready inputs are active low: high means the far end is full
  assign remoteBusy = ((flowMode == FLOW_RTSCTS) & gpioSync[`UFM_PIN_CTS])
                    | ((flowMode == FLOW_DTRDSR) & gpioSync[`UFM_PIN_REMOTE_RDY]);
  assign dataBits = nineBit ? `UFM_DATA_BITS9 : `UFM_DATA_BITS8;
  assign suspendCtl = usbSuspended & useSuspend;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue between the channel FIFO and the shifter
  ufm_fifo #(
    .WIDTH(`UFM_WORD_W),
    .DEPTH(`UFM_TXQ_DEPTH)
  ) txQueue (
    .clock(clock),
    .reset_n(reset_n),
    .inData(txWord),
    .inValid(txValid),
    .inReady(txReady),
    .outData(qData),
    .outValid(qValid),
    .outReady(qReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load selection: a flow character beats queued data, and nothing starts
  // while a character is being shifted, so only a USB suspend cuts a frame
  logic txFree;
  logic sendFlow;
  logic sendData;
  logic [8:0] loadWord;

  assign txFree = txState != TX_SHIFT;
  assign sendFlow = txFree & pendValid & ~usbSuspended;
  assign sendData = txFree & ~pendValid & qValid & ~usbSuspended
                  & ~softHalt
                  & ~remoteBusy
                  & ~((flowMode == FLOW_ADDR_GATED) & ~addrOpen);
  assign qReady = sendData;
  assign loadWord = pendValid ? {1'b0, pendChar} : qData;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter and turn-around hold
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txState <= TX_IDLE;
      txShift <= 11'h7ff;
      txBits <= 4'h0;
      txSub <= 4'h0;
      holdCnt <= 4'h0;
    end else if (usbSuspended) begin
      txState <= TX_IDLE;
      txShift <= 11'h7ff;
    end else if (sendFlow | sendData) begin
      txState <= TX_SHIFT;
      txShift <= {1'b1, nineBit ? loadWord[8] : 1'b1, loadWord[7:0], 1'b0};
      txBits <= nineBit ? `UFM_FRAME_BITS9 : `UFM_FRAME_BITS8;
      txSub <= 4'h0;
    end else if (subTick) begin
      // Bit times follow the baud tick, so the hold tracks the current rate
      txSub <= txSub + 4'h1;
      unique case (txState)
        TX_IDLE: begin
        end
        TX_SHIFT: begin
          if (txSub == `UFM_SUB_LAST) begin
            txShift <= {1'b1, txShift[10:1]};
            txBits <= txBits - 4'h1;
            if (txBits == 4'h1) begin
              if (rs485Enable && turnaroundDelaySetting != 4'h0) begin
                txState <= TX_HOLD;
                holdCnt <= turnaroundDelaySetting;
              end else begin
                txState <= TX_IDLE;
              end
            end
          end
        end
        TX_HOLD: begin
          if (txSub == `UFM_SUB_LAST) begin
            holdCnt <= holdCnt - 4'h1;
            if (holdCnt == 4'h1) txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output; IR idles low and pulses in the middle of zero bits
  logic irWindow;
  logic irPulse;

  assign irWindow = (txSub >= (irPulseWide ? `UFM_IR_BEG4 : `UFM_IR_BEG3))
                  & (txSub <= `UFM_IR_END);
  assign irPulse = (txState == TX_SHIFT) & ~txShift[0] & irWindow;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      serialTx <= 1'b1;
    end else if (usbSuspended) begin
      serialTx <= 1'b1;
    end else begin
      serialTx <= infraredSetting ? irPulse : txShift[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow character requests; only one waits at a time so order is kept
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pendValid <= 1'b0;
      pendChar <= 8'h00;
      stopSent <= 1'b0;
    end else if (sendFlow) begin
      pendValid <= 1'b0;
    end else if (!softMode) begin
      stopSent <= 1'b0;
    end else if (!pendValid) begin
      if (rxFull && !stopSent) begin
        pendValid <= 1'b1;
        pendChar <= stopCharRegister;
        stopSent <= 1'b1;
      end else if (!rxFull && stopSent) begin
        pendValid <= 1'b1;
        pendChar <= startCharRegister;
        stopSent <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // IR receive: stretch each pulse to a full low bit for the receiver
  logic irPin;
  logic rxLine;
  logic rxBlocked;

  assign irPin = rxSync ^ irRxInvert;
  assign rxLine = infraredSetting ? ~(irPin | (irHold != 4'h0)) : rxSync;
  // Suspend also parks the receiver, so the line reads as idle
  assign rxBlocked = usbSuspended | (halfDuplex & (txState == TX_SHIFT));

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irHold <= 4'h0;
    end else if (infraredSetting && irPin) begin
      irHold <= `UFM_SUB_LAST;
    end else if (subTick && irHold != 4'h0) begin
      irHold <= irHold - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, sampling mid-bit
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rxState <= RX_IDLE;
      rxSub <= 4'h0;
      rxIdx <= 4'h0;
      rxShift <= 9'h000;
      rxDone <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (rxBlocked) begin
        rxState <= RX_IDLE;
      end else begin
        unique case (rxState)
          RX_IDLE: begin
            if (!rxLine) begin
              rxState <= RX_SHIFT;
              rxSub <= 4'h0;
              rxIdx <= 4'h0;
            end
          end
          RX_SHIFT: begin
            if (subTick) begin
              rxSub <= rxSub + 4'h1;
              if (rxSub == `UFM_SUB_MID) begin
                rxIdx <= rxIdx + 4'h1;
                if (rxIdx == 4'h0 && rxLine) begin
                  rxState <= RX_IDLE; // Glitch, not a start bit
                end else if (rxIdx == dataBits + 4'h1) begin
                  rxState <= RX_IDLE;
                  rxDone <= 1'b1;
                end else if (rxIdx != 4'h0) begin
                  rxShift <= {rxLine, rxShift[8:1]};
                end
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received character filtering: flow characters and address matching
  logic [8:0] rxGot;
  logic addrFlag;
  logic charMatch;
  logic isStop;
  logic isStart;
  logic keep;

  assign rxGot = nineBit ? rxShift : {1'b0, rxShift[8:1]};
  assign addrFlag = nineBit ? rxGot[8] : rxGot[7];
  assign charMatch = (rxGot[7:0] == startCharRegister) | (rxGot[7:0] == stopCharRegister);
  assign isStop = softMode & (rxGot[7:0] == stopCharRegister);
  assign isStart = softMode & (rxGot[7:0] == startCharRegister);
  // Flow characters are consumed; in address modes matching addresses and data in an open window store
  assign keep = softMode ? ~(isStop | isStart)
              : addrMode ? (addrFlag ? charMatch : addrOpen)
              : 1'b1;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rxValid <= 1'b0;
      rxWord <= 9'h000;
    end else begin
      rxValid <= rxDone & keep;
      if (rxDone && keep) rxWord <= rxGot;
    end
  end

  // Halt flag; a stop character wins if both characters are equal
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      softHalt <= 1'b0;
    end else if (rxDone && isStop) begin
      softHalt <= 1'b1;
    end else if ((rxDone && isStart) || !softMode) begin
      softHalt <= 1'b0;
    end
  end

  // Address window; it also gates the transmitter in mode 4
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      addrOpen <= 1'b0;
    end else if (!addrMode) begin
      addrOpen <= 1'b0;
    end else if (rxDone && addrFlag) begin
      addrOpen <= charMatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // USB status pins
  function automatic logic statusOf(input ufm_stat_t sel);
    unique case (sel)
      STAT_SUSPEND: statusOf = usbSuspended;
      STAT_LOWPWR: statusOf = usbSuspended | (highPowerDevice & ~usbConfigured);
      STAT_BUSRST: statusOf = usbBusReset;
      default: statusOf = 1'b0;
    endcase
  endfunction : statusOf

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      usbStat1 <= 1'b0;
      usbStat2 <= 1'b0;
    end else begin
      usbStat1 <= statusOf(stat1Select) ^ stat1Invert;
      usbStat2 <= statusOf(stat2Select) ^ stat2Invert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // GPIO pin drive: special functions over software values, then suspend
  logic hdxActive;
  logic [3:0] hdxPin;

  assign hdxActive = txState != TX_IDLE;
  assign hdxPin = rs485PinSel ? 4'(`UFM_PIN_HDX_B) : 4'(`UFM_PIN_HDX_A);

  always_comb begin
    next_gpioPinOut = gpioOut;
    next_gpioPinOe = gpioOe;
    if (flowMode == FLOW_RTSCTS) begin
      next_gpioPinOut[`UFM_PIN_RTS] = localReadyN;
      next_gpioPinOe[`UFM_PIN_RTS] = 1'b1;
    end
    if (flowMode == FLOW_DTRDSR) begin
      next_gpioPinOut[`UFM_PIN_LOCAL_RDY] = localReadyN;
      next_gpioPinOe[`UFM_PIN_LOCAL_RDY] = 1'b1;
    end
    if (rs485Enable) begin
      next_gpioPinOut[hdxPin] = hdxActive;
      next_gpioPinOe[hdxPin] = 1'b1;
    end
    if (clkOutEnable) begin
      next_gpioPinOut[`UFM_PIN_CLK] = clkOutLevel;
      next_gpioPinOe[`UFM_PIN_CLK] = 1'b1;
    end
    if (suspendCtl) begin
      // Open-drain pins only pull low, so a high level floats
      next_gpioPinOut = suspendLevel;
      next_gpioPinOe = ~(suspendOpenDrain & suspendLevel);
      if (clkOutEnable) begin
        next_gpioPinOut[`UFM_PIN_CLK] = 1'b0;
        next_gpioPinOe[`UFM_PIN_CLK] = 1'b1;
      end
      if (rs485Enable) begin
        next_gpioPinOut[hdxPin] = 1'b0;
        next_gpioPinOe[hdxPin] = 1'b1;
      end
    end
  end

  // Without suspend control the pins simply freeze while suspended
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gpioPinOut <= '0;
      gpioPinOe <= '0;
    end else if (!(usbSuspended && !useSuspend)) begin
      gpioPinOut <= next_gpioPinOut;
      gpioPinOe <= next_gpioPinOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity toggles; the counter keeps its place while the line rests
  logic [1:0] lineActive;

  assign lineActive = {rxState == RX_SHIFT, txState == TX_SHIFT};

  genvar g;
  for (g = 0; g < 2; g++) begin : gAct
    logic [31:0] cnt;
    logic tog;
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cnt <= 32'h0;
        tog <= 1'b0;
      end else if (lineActive[g]) begin
        if (cnt >= 32'(ACT_CYCLES - 1)) begin
          cnt <= 32'h0;
          tog <= ~tog;
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
    assign actPin[g] = tog;
  end

  assign txActivityPin = actPin[0];
  assign rxActivityPin = actPin[1];

endmodule : ufm_line_ctrl

`default_nettype wire

// ==== testbench/ufm_props.sv ====
// Port checks for the line control block.
// Assumes binding onto the top; sees only its ports.
`timescale 1ns/1ps
`include "ufm_params.svh"
`default_nettype none
module ufm_chk
  import ufm_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire ufm_flow_t flowMode,
  input wire logic [9:0] rxThreshold,
  input wire logic [9:0] rxFifoLevel,
  input wire logic [9:0] gpioPinOut,
  input wire logic [9:0] suspendLevel,
  input wire logic usbSuspended,
  input wire logic useSuspend,
  input wire logic usbBusReset,
  input wire ufm_stat_t stat1Select,
  input wire logic stat1Invert,
  input wire ufm_stat_t stat2Select,
  input wire logic stat2Invert,
  input wire logic usbStat1,
  input wire logic usbStat2,
  input wire logic serialTx,
  input wire logic rxValid
);
  // One domain; reset silences every check
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Ready pins are registered, so the fill must hold two cycles
  a_rts_at_limit:
    assert property ((flowMode == FLOW_RTSCTS && !usbSuspended && rxThreshold == 10'h000
      && rxFifoLevel >= 10'h1c2)[*2] |-> gpioPinOut[`UFM_PIN_RTS]) else $error("rts low");
  a_dtr_below:
    assert property ((flowMode == FLOW_DTRDSR && !usbSuspended && rxThreshold == 10'h000
      && rxFifoLevel < 10'h1c2)[*2] |-> !gpioPinOut[`UFM_PIN_LOCAL_RDY]) else $error("dtr");
  // Status pins lag their cause by one cycle
  a_stat_suspend:
    assert property ($past(reset_n) && $past(stat1Select) == STAT_SUSPEND
      |-> usbStat1 == ($past(usbSuspended) ^ $past(stat1Invert))) else $error("stat1");
  a_stat_busrst:
    assert property ($past(reset_n) && $past(stat2Select) == STAT_BUSRST
      |-> usbStat2 == ($past(usbBusReset) ^ $past(stat2Invert))) else $error("stat2");
  // Suspend parks the line and the pins
  a_susp_tx_idle:
    assert property (usbSuspended[*2] |-> serialTx) else $error("tx not idle");
  a_susp_no_rx:
    assert property (usbSuspended[*3] |-> !rxValid) else $error("rx in suspend");
  a_susp_hold:
    assert property ((usbSuspended && !useSuspend)[*3] |-> $stable(gpioPinOut))
      else $error("pins moved");
  a_susp_level:
    assert property ((usbSuspended && useSuspend && $stable(suspendLevel))[*2]
      |-> gpioPinOut[9:8] == suspendLevel[9:8]) else $error("level");
endmodule : ufm_chk
bind ufm_line_ctrl ufm_chk u_chk (.clock, .reset_n, .flowMode, .rxThreshold, .rxFifoLevel,
  .gpioPinOut, .suspendLevel, .usbSuspended, .useSuspend, .usbBusReset, .stat1Select,
  .stat1Invert, .stat2Select, .stat2Invert, .usbStat1, .usbStat2, .serialTx, .rxValid);
`default_nettype wire

// ==== testbench/ufm_remote.sv ====
// Remote UART on the serial pins, 16 clocks per bit.
// Assumes the tick input of the block runs every cycle.
`timescale 1ns/1ps
`default_nettype none
module ufm_remote (
  input wire logic clock,
  input wire logic lineIn,
  output logic lineOut,
  output logic [7:0] gotByte,
  output int gotCount
);
  initial lineOut = 1'b1;
  // Caller keeps the flag bit of addresses set
  task automatic sendByte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      lineOut <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (16) @(posedge clock);
    end
  endtask : sendByte
  // Receiver samples mid-bit; stop bit not checked
  initial begin
    gotCount = 0;
    forever begin
      @(negedge lineIn);
      repeat (8) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge clock);
        gotByte[i] = lineIn;
      end
      repeat (16) @(posedge clock);
      gotCount++;
    end
  end
endmodule : ufm_remote
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Bench for the line control block: sequences of line, queue and USB state.
// Assumes the remote model on the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %0h", $time, a); end end
module tb_top
  import ufm_pkg::*;
;
  logic clock, reset_n, hdx, nine, rsEn, rsSel, ir, irW, irInv, txValid, txReady, rxValid;
  logic serialTx, serialRx, clkEn, clkLv, useSusp, susp, cfg, busRst, hiPwr, inv1, inv2;
  logic stat1, stat2, txAct, rxAct;
  logic [3:0] dly;
  logic [1:0] actQ = '0;
  logic [9:0] thr, level, gOut, gOe, pinOut, pinOe, sLevel, sOd, gIn;
  logic [8:0] txWord, rxWord, lastRx;
  logic [7:0] gotByte;
  logic [7:0] seq [5] = '{8'h12, 8'hb6, 8'h12, 8'hc3, 8'h34};
  ufm_flow_t mode;
  ufm_stat_t sel1, sel2;
  int err_total = 0, tests_run = 0, rxCount = 0, gotCount, cyc = 0, togs = 0;
  ufm_line_ctrl #(.ACT_CYCLES(20)) u_dut (.clock, .reset_n, .subTick(1'b1), .flowMode(mode),
    .halfDuplex(hdx), .nineBit(nine), .rxThreshold(thr), .startCharRegister(8'ha5),
    .stopCharRegister(8'hb6), .rs485Enable(rsEn), .rs485PinSel(rsSel),
    .turnaroundDelaySetting(dly), .infraredSetting(ir), .irPulseWide(irW), .irRxInvert(irInv),
    .txWord, .txValid, .txReady, .rxWord, .rxValid, .rxFifoLevel(level), .serialTx, .serialRx,
    .gpioIn(gIn), .gpioOut(gOut), .gpioOe(gOe), .gpioPinOut(pinOut), .gpioPinOe(pinOe),
    .clkOutEnable(clkEn), .clkOutLevel(clkLv), .useSuspend(useSusp), .suspendLevel(sLevel),
    .suspendOpenDrain(sOd), .usbSuspended(susp), .usbConfigured(cfg), .usbBusReset(busRst),
    .highPowerDevice(hiPwr), .stat1Select(sel1), .stat1Invert(inv1), .stat2Select(sel2),
    .stat2Invert(inv2), .usbStat1(stat1), .usbStat2(stat2), .txActivityPin(txAct),
    .rxActivityPin(rxAct));
  ufm_remote u_rem (.clock, .lineIn(serialTx), .lineOut(serialRx), .gotByte, .gotCount);
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Offer one word; caller drops valid after the last one
  task automatic push(input logic [8:0] w);
    txWord <= w;
    txValid <= 1'b1;
    @(posedge clock);
  endtask : push
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Log kept words; a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    // Activity toggles counted on both pins; unknowns before reset do not count
    togs += int'(actQ[0] != txAct) + int'(actQ[1] != rxAct);
    actQ = {rxAct, txAct};
    if (rxValid === 1'b1) begin
      rxCount++;
      lastRx = rxWord;
    end
    if (cyc > 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {reset_n, hdx, nine, rsEn, rsSel, ir, irW, irInv, txValid, clkEn, clkLv, gIn, dly} = '0;
    {useSusp, susp, cfg, busRst, hiPwr, inv1, inv2, thr, level, gOut, gOe, sLevel, sOd} = '0;
    txWord = 9'h000;
    mode = FLOW_ADDR_FREE;
    sel1 = STAT_SUSPEND;
    sel2 = STAT_BUSRST;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Address window starts closed, opens on the stop character, closes on others
    foreach (seq[i]) u_rem.sendByte(seq[i]);
    repeat (4) @(posedge clock);
    `CHK(rxCount, 2)
    `CHK(lastRx, 9'h012)
    `CHK(togs, 38)
    // Gated transmit waits for a match
    mode <= FLOW_ADDR_GATED;
    push(9'h05a);
    txValid <= 1'b0;
    repeat (400) @(posedge clock);
    `CHK(gotCount, 0)
    u_rem.sendByte(8'ha5);
    repeat (200) @(posedge clock);
    `CHK(gotByte, 8'h5a)
    // Soft flow: halted queue fills until refused, then drains after resume
    mode <= FLOW_SOFT;
    u_rem.sendByte(8'hb6);
    for (int i = 1; i < 5; i++) push(9'h0c0 + 9'(i));
    txValid <= 1'b0;
    #1;
    `CHK(txReady, 1'b0)
    u_rem.sendByte(8'ha5);
    repeat (720) @(posedge clock);
    `CHK(gotCount, 5)
    `CHK(togs, 100)
    `CHK(gotByte, 8'hc4)
    `CHK(rxCount, 3)
    level <= 10'h1c2;
    repeat (200) @(posedge clock);
    `CHK(gotByte, 8'hb6)
    level <= 10'h1c1;
    repeat (200) @(posedge clock);
    `CHK(gotByte, 8'ha5)
    // Hardware ready pins against the fill
    mode <= FLOW_RTSCTS;
    level <= 10'h1c2;
    gIn <= 10'h010;
    rsEn <= 1'b1;
    dly <= 4'h2;
    hdx <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(pinOut[5], 1'b1)
    // Far end busy holds the word; release starts it over a colliding receive
    push(9'h011);
    txValid <= 1'b0;
    repeat (200) @(posedge clock);
    `CHK(gotCount, 7)
    gIn <= 10'h000;
    u_rem.sendByte(8'h77);
    wait (gotCount == 8);
    `CHK(rxCount, 3)
    `CHK(gotByte, 8'h11)
    repeat (20) @(posedge clock);
    `CHK(pinOut[7], 1'b1)
    repeat (30) @(posedge clock);
    `CHK(pinOut[7], 1'b0)
    mode <= FLOW_DTRDSR;
    level <= 10'h005;
    repeat (4) @(posedge clock);
    `CHK(pinOut[3], 1'b0)
    // Suspend: pins hold, then forced levels; status pins follow USB state
    mode <= FLOW_NONE;
    clkEn <= 1'b1;
    clkLv <= 1'b1;
    gOe <= 10'h3ff;
    gOut <= 10'h155;
    inv2 <= 1'b1;
    repeat (4) @(posedge clock);
    susp <= 1'b1;
    repeat (4) @(posedge clock);
    gOut <= 10'h0aa;
    repeat (4) @(posedge clock);
    `CHK(pinOut, 10'h155)
    `CHK(stat1, 1'b1)
    `CHK(stat2, 1'b1)
    sLevel <= 10'h30f;
    sOd <= 10'h003;
    useSusp <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(pinOut, 10'h30e)
    `CHK(pinOe, 10'h3fd)
    `CHK(serialTx, 1'b1)
    susp <= 1'b0;
    busRst <= 1'b1;
    inv2 <= 1'b0;
    sel1 <= STAT_LOWPWR;
    hiPwr <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(stat2, 1'b1)
    `CHK(stat1, 1'b1)
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
